// File: core/bus_trace_status_qualifier.sv
// Capture and qualifier core of an emulation-bus trace analyzer.
// Assumes processor pins are asynchronous to pclk and an APB master.
//
// Summary of operation
// - Each bus state is one 80-channel word stored as one entry.
// - Channels 0-31 hold address; top four from pins or rebuilt value.
// - Channels 32-63 hold the 32 data lines.
// - Channels 64-79 form the 16-bit status field.
// - Status bit 0 reserved; bits 1-3 are the low function codes.
// - Status bit 4 is read/write, one meaning read.
// - Status bits 6:5 are transfer size: long, byte, word, three-byte.
// - Status bits 8:7 are port acknowledges giving 8, 16, 32-bit port.
// - Status bit 9 is bus error; bits 9 and 10 low mean retry.
// - Status bit 10 low marks a halted processor.
// - Status bit 11 low marks a show cycle, kept only when enabled.
// - Status bit 12 low on the first fetch after a pipeline flush.
// - Status bit 13 low for external DMA cycles.
// - Status bit 14 is the top function code; bit 15 low on fetch.
// - Space decodes need bit 14 low; cpu, data, program, sup, user.
// - Combined decodes for supervisor and user data and program.
// - Masked status patterns qualify both trigger and storage.
// - Address plus read status matches reads only, not writes.
// - Trace buffer holds 1024 states, or 512 with counting on.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
module bus_trace_status_qualifier
   import trace_qual_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Observed processor bus
   input wire logic [27:0] addr_lo,
   input wire logic [3:0] addr_hi,
   input wire logic [3:0] recon_addr,
   input wire logic [31:0] data,
   input wire logic [3:0] func_code,
   input wire logic rd_wr,
   input wire logic xfer_size_low,
   input wire logic xfer_size_high,
   input wire logic port_ack_low_n,
   input wire logic port_ack_high_n,
   input wire logic bus_err_n,
   input wire logic halt_n,
   input wire logic show_cycle_n,
   input wire logic fetch_n,
   input wire logic ext_dma,
   input wire logic pipe_flush,
   input wire logic cycle_done,
   // Analyzer results
   output logic triggered,
   output logic trace_full,
   output logic store_pulse,
   output logic [NUM_EQ-1:0] eq_hits
);
   default clocking dcb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_s1_r;
   logic [PIN_W-1:0] pin_s2_r;
   logic [PIN_W-1:0] pin_s3_r;
   logic [PIN_W-1:0] pin_st_r;
   logic [PIN_W-1:0] pin_st_nxt;

   assign pin_raw = {cycle_done, pipe_flush, ext_dma, fetch_n, show_cycle_n, halt_n,
                     bus_err_n, port_ack_high_n, port_ack_low_n, xfer_size_high,
                     xfer_size_low, rd_wr, func_code, data, recon_addr, addr_hi, addr_lo};

   // A bit only moves once stages two and three agree
   assign pin_st_nxt = (pin_s2_r & pin_s3_r) | (pin_st_r & (pin_s2_r ^ pin_s3_r));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         pin_s3_r <= '0;
         pin_st_r <= '0;
      end else begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         pin_st_r <= pin_st_nxt;
      end
   end

   logic s_done, s_flush, s_dma, s_fetch_n, s_show_n, s_halt_n, s_berr_n;
   logic s_ackh_n, s_ackl_n, s_szh, s_szl, s_rw;
   logic [3:0] s_fc;
   logic [31:0] s_data;
   logic [3:0] s_recon;
   logic [3:0] s_ahi;
   logic [27:0] s_alo;

   assign {s_done, s_flush, s_dma, s_fetch_n, s_show_n, s_halt_n, s_berr_n, s_ackh_n,
           s_ackl_n, s_szh, s_szl, s_rw, s_fc, s_data, s_recon, s_ahi, s_alo} = pin_st_r;

   // ***************************************************************
   // Control registers
   // ***************************************************************
   logic [4:0] ctrl_r;
   logic [PTR_W-1:0] rdidx_r;
   logic wr_en;
   logic clr;

   assign wr_en = psel & penable & pwrite;
   assign clr = wr_en & (paddr == REG_CTRL) & pwdata[CTL_CLR];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= CTRL_RST;
         rdidx_r <= '0;
      end else begin
         if (wr_en && paddr == REG_CTRL) begin
            ctrl_r <= {1'b0, pwdata[CTL_SHOWEN:0]};
         end
         if (wr_en && paddr == REG_RDIDX) begin
            rdidx_r <= pwdata[PTR_W-1:0];
         end
      end
   end

   // ***************************************************************
   // Capture word
   // ***************************************************************
   logic done_d_r;
   logic cap;
   logic flush_pend_r;
   logic [STAT_W-1:0] stat_w;
   logic [WORD_W-1:0] word_w;
   logic [3:0] top_addr;

   assign cap = s_done & ~done_d_r;
   assign top_addr = ctrl_r[CTL_RECON] ? s_recon : s_ahi;

   assign stat_w = {s_fetch_n, s_fc[3], ~s_dma,
                    ~(flush_pend_r & ~s_fetch_n),
                    s_show_n, s_halt_n, s_berr_n,
                    s_ackh_n, s_ackl_n, s_szh, s_szl,
                    s_rw, s_fc[2:0], 1'b0};
   assign word_w = {stat_w, s_data, top_addr, s_alo};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_d_r <= 1'b0;
      end else begin
         done_d_r <= s_done;
      end
   end

   // A new flush beats the fetch that would consume the old one
   logic flush_d_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flush_d_r <= 1'b0;
         flush_pend_r <= 1'b0;
      end else begin
         flush_d_r <= s_flush;
         if (s_flush && !flush_d_r) begin
            flush_pend_r <= 1'b1;
         end else if (cap && !s_fetch_n) begin
            flush_pend_r <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // Status equates
   // ***************************************************************
   logic [NUM_EQ-1:0] eq_now;

   genvar e;
   generate
      for (e = 0; e < NUM_EQ; e++) begin : g_eq
         assign eq_now[e] = &(~(stat_w ^ EQ_TAB[e][15:0]) | ~EQ_TAB[e][31:16]);
      end
   endgenerate

   // ***************************************************************
   // Trigger (0) and storage (1) qualifiers
   // ***************************************************************
   logic [31:0] qav_r [2];
   logic [31:0] qam_r [2];
   logic [31:0] qdv_r [2];
   logic [31:0] qdm_r [2];
   logic [31:0] qst_r [2];
   logic [1:0] q_hit;

   genvar q;
   generate
      for (q = 0; q < 2; q++) begin : g_q
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               qav_r[q] <= QREG_RST;
               qam_r[q] <= QREG_RST;
               qdv_r[q] <= QREG_RST;
               qdm_r[q] <= QREG_RST;
               qst_r[q] <= QREG_RST;
            end else if (wr_en && paddr[11:6] == REG_QBLK && paddr[5] == q) begin
               case (paddr[4:2])
                  QF_AV: qav_r[q] <= pwdata;
                  QF_AM: qam_r[q] <= pwdata;
                  QF_DV: qdv_r[q] <= pwdata;
                  QF_DM: qdm_r[q] <= pwdata;
                  QF_ST: qst_r[q] <= pwdata;
                  default: ;
               endcase
            end
         end

         // Address, data and status cares all apply at once
         qual_match u_match (
            .word (word_w),
            .value ({qst_r[q][15:0], qdv_r[q], qav_r[q]}),
            .care ({qst_r[q][31:16], qdm_r[q], qam_r[q]}),
            .hit (q_hit[q])
         );
      end
   endgenerate

   // ***************************************************************
   // Trace store
   // ***************************************************************
   logic [10:0] wptr_r;
   logic [10:0] depth;
   logic [PTR_W-1:0] trig_pos_r;
   logic [31:0] scnt_r;
   logic [WORD_W-1:0] state_r;
   logic [WORD_W-1:0] rd_word;
   logic triggered_r;
   logic visible;
   logic we;

   // Counting reserves half the store, so depth drops to 512
   assign depth = ctrl_r[CTL_CNT] ? DEPTH_CNT : DEPTH_FULL;
   assign trace_full = (wptr_r >= depth);
   assign visible = s_show_n | ctrl_r[CTL_SHOWEN];
   assign we = cap & ctrl_r[CTL_ARM] & q_hit[1] & visible & ~trace_full;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wptr_r <= '0;
         store_pulse <= 1'b0;
      end else begin
         store_pulse <= we;
         if (clr) begin
            wptr_r <= '0;
         end else if (we) begin
            wptr_r <= wptr_r + 11'h001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         triggered_r <= 1'b0;
         trig_pos_r <= '0;
      end else if (cap && ctrl_r[CTL_ARM] && q_hit[0] && visible && (!triggered_r || clr)) begin
         triggered_r <= 1'b1;
         trig_pos_r <= wptr_r[PTR_W-1:0];
      end else if (clr) begin
         triggered_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scnt_r <= '0;
      end else if (clr) begin
         scnt_r <= '0;
      end else if (cap && ctrl_r[CTL_ARM] && ctrl_r[CTL_CNT]) begin
         scnt_r <= scnt_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= '0;
         eq_hits <= '0;
      end else if (cap) begin
         state_r <= word_w;
         eq_hits <= eq_now;
      end
   end

   assign triggered = triggered_r;

   trace_ram u_ram (
      .pclk (pclk),
      .we (we),
      .waddr (wptr_r[PTR_W-1:0]),
      .wdata (word_w),
      .raddr (rdidx_r),
      .rdata (rd_word)
   );

   // ***************************************************************
   // APB read path
   // ***************************************************************
   logic [31:0] rd_nxt;
   logic err_nxt;

   always_comb begin
      rd_nxt = 32'h0000_0000;
      err_nxt = 1'b0;
      if (paddr[11:6] == REG_QBLK) begin
         case (paddr[4:2])
            QF_AV: rd_nxt = qav_r[paddr[5]];
            QF_AM: rd_nxt = qam_r[paddr[5]];
            QF_DV: rd_nxt = qdv_r[paddr[5]];
            QF_DM: rd_nxt = qdm_r[paddr[5]];
            QF_ST: rd_nxt = qst_r[paddr[5]];
            default: err_nxt = 1'b1;
         endcase
      end else begin
         case (paddr)
            REG_CTRL: rd_nxt = {27'h0, ctrl_r};
            REG_STAT: rd_nxt = {5'h00, wptr_r, 13'h0000, flush_pend_r, trace_full, triggered_r};
            REG_EQHIT: rd_nxt = {7'h00, eq_hits};
            REG_RDIDX: rd_nxt = {22'h000000, rdidx_r};
            REG_TW0: rd_nxt = rd_word[31:0];
            REG_TW1: rd_nxt = rd_word[63:32];
            REG_TW2: rd_nxt = {16'h0000, rd_word[WORD_W-1:STAT_LSB]};
            REG_TRIGPOS: rd_nxt = {22'h000000, trig_pos_r};
            REG_CUR0: rd_nxt = state_r[31:0];
            REG_CUR1: rd_nxt = state_r[63:32];
            REG_CUR2: rd_nxt = {16'h0000, state_r[WORD_W-1:STAT_LSB]};
            REG_SCNT: rd_nxt = scnt_r;
            default: err_nxt = 1'b1;
         endcase
      end
   end

   // Read data is latched in the setup cycle so it comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
         pslverr <= err_nxt;
      end
   end

   assign pready = 1'b1;

   // ***************************************************************
   // Checks
   // ***************************************************************
   addr_chan_a: assert property (cap |=> state_r[31:0] == {$past(top_addr), $past(s_alo)})
      else $error("address channels wrong");
   data_chan_a: assert property (cap |=> state_r[63:32] == $past(s_data))
      else $error("data channels wrong");
   fc_low_a: assert property (cap |=> state_r[67:64] == {$past(s_fc[2:0]), 1'b0})
      else $error("function code or reserved bit wrong");
   rw_chan_a: assert property (cap |=> state_r[STAT_LSB+ST_RW] == $past(s_rw))
      else $error("read/write channel wrong");
   read_equate_a: assert property (cap |=> eq_hits[EQ_READ] == state_r[STAT_LSB+ST_RW])
      else $error("read equate disagrees");
   retry_equate_a: assert property (cap |=> eq_hits[EQ_RETRY] ==
         (!state_r[STAT_LSB+ST_BERR] && !state_r[STAT_LSB+ST_HALT]))
      else $error("retry decode wrong");
   flush_flag_a: assert property (cap && flush_pend_r && !s_fetch_n && !(s_flush && !flush_d_r)
         |=> !state_r[STAT_LSB+ST_FLUSH] && !flush_pend_r)
      else $error("flush flag not shown");
   xdma_chan_a: assert property (cap |=> state_r[STAT_LSB+ST_XDMA] == !$past(s_dma))
      else $error("dma bit wrong");
   depth_bound_a: assert property (wptr_r > depth |-> wptr_r == $past(wptr_r))
      else $error("store past depth");
   store_qual_a: assert property (we |-> q_hit[1] && ctrl_r[CTL_ARM] ##1 store_pulse &&
         (wptr_r == $past(wptr_r) + 11'h001 || $past(clr)))
      else $error("unqualified store");

   trig_seen_c: cover property (cap && q_hit[0] && ctrl_r[CTL_ARM] ##1 triggered_r);
   buf_full_c: cover property (we ##1 trace_full);
   read_hit_c: cover property (cap && eq_now[EQ_READ] && q_hit[1]);
endmodule

// File: core/qual_match.sv
// Masked compare of one capture word against a value and care mask.
// Assumes the word, value and mask are all stable in the same cycle.
`timescale 1ns/1ps
module qual_match
   import trace_qual_pkg::*;
(
   // Compare operands
   input wire logic [WORD_W-1:0] word,
   input wire logic [WORD_W-1:0] value,
   input wire logic [WORD_W-1:0] care,
   // Result
   output logic hit
);
   // Don't-care bits are forced true so they never take part
   assign hit = &(~(word ^ value) | ~care);
endmodule

// File: core/trace_qual_pkg.sv
// Constants for the bus trace capture and status qualifier block.
// Assumes one clock (pclk) shared by the APB slave and the capture logic.
package trace_qual_pkg;

   // ***************************************************************
   // Word layout
   // ***************************************************************
   localparam int WORD_W = 80;
   localparam int STAT_W = 16;
   localparam int PIN_W = 84;
   localparam int PTR_W = 10;
   localparam int DATA_LSB = 32;
   localparam int STAT_LSB = 64;
   localparam logic [10:0] DEPTH_FULL = 11'h400;
   localparam logic [10:0] DEPTH_CNT = 11'h200;

   // Status field bit positions
   localparam int ST_RSVD = 0;
   localparam int ST_FC_LSB = 1;
   localparam int ST_RW = 4;
   localparam int ST_SIZ_LSB = 5;
   localparam int ST_ACK_LSB = 7;
   localparam int ST_BERR = 9;
   localparam int ST_HALT = 10;
   localparam int ST_SHOW = 11;
   localparam int ST_FLUSH = 12;
   localparam int ST_XDMA = 13;
   localparam int ST_FC3 = 14;
   localparam int ST_FETCH = 15;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_STAT = 12'h004;
   localparam logic [11:0] REG_EQHIT = 12'h008;
   localparam logic [11:0] REG_RDIDX = 12'h00C;
   localparam logic [11:0] REG_TW0 = 12'h010;
   localparam logic [11:0] REG_TW1 = 12'h014;
   localparam logic [11:0] REG_TW2 = 12'h018;
   localparam logic [11:0] REG_TRIGPOS = 12'h01C;
   localparam logic [11:0] REG_CUR0 = 12'h020;
   localparam logic [11:0] REG_CUR1 = 12'h024;
   localparam logic [11:0] REG_CUR2 = 12'h028;
   localparam logic [11:0] REG_SCNT = 12'h02C;
   localparam logic [5:0] REG_QBLK = 6'h01;
   localparam logic [2:0] QF_AV = 3'h0;
   localparam logic [2:0] QF_AM = 3'h1;
   localparam logic [2:0] QF_DV = 3'h2;
   localparam logic [2:0] QF_DM = 3'h3;
   localparam logic [2:0] QF_ST = 3'h4;

   localparam int CTL_ARM = 0;
   localparam int CTL_CNT = 1;
   localparam int CTL_RECON = 2;
   localparam int CTL_SHOWEN = 3;
   localparam int CTL_CLR = 4;
   localparam logic [4:0] CTRL_RST = 5'h00;
   localparam logic [31:0] QREG_RST = 32'h0000_0000;
   localparam int STAT_WPTR_LSB = 16;

   // ***************************************************************
   // Status equates, {care[15:0], value[15:0]}
   // ***************************************************************
   localparam int NUM_EQ = 25;
   localparam int EQ_FLUSH = 8;
   localparam int EQ_READ = 11;
   localparam int EQ_RETRY = 12;
   localparam int EQ_XDMA = 24;
   localparam logic [31:0] EQ_TAB [NUM_EQ] = '{
      32'h0200_0000, 32'h400E_000E, 32'h4006_0002, // bus error, cpu, data
      32'h0180_0100, 32'h0180_0000, 32'h0180_0080, // port8, port32, port16
      32'h4000_4000, 32'h8000_0000, 32'h1000_0000, // fc top, fetch, flush
      32'h0400_0000, 32'h4006_0004, 32'h0010_0010, // halt, program, read
      32'h0600_0000, 32'h0060_0060, 32'h0060_0020, // retry, 3 byte, byte
      32'h0060_0000, 32'h0060_0040, 32'h4008_0008, // long, word, sup
      32'h400E_000A, 32'h400E_000C, 32'h4008_0000, // sup data, sup prog, user
      32'h400E_0002, 32'h400E_0004, 32'h0010_0000, // user data, user prog, write
      32'h2000_0000                                // external dma
   };

endpackage

// File: core/trace_ram.sv
// Trace store: one 80-bit word per entry, registered read port.
// Assumes a single clock; write and read may hit the same entry.
`timescale 1ns/1ps
module trace_ram
   import trace_qual_pkg::*;
(
   // Clock
   input wire logic pclk,
   // Write port
   input wire logic we,
   input wire logic [PTR_W-1:0] waddr,
   input wire logic [WORD_W-1:0] wdata,
   // Read port
   input wire logic [PTR_W-1:0] raddr,
   output logic [WORD_W-1:0] rdata
);
   logic [WORD_W-1:0] mem [DEPTH_FULL];

   // No reset: contents are only meaningful below the write pointer
   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

// File: verif/cpu_bus_model.sv
// Processor bus model that drives the observed pins of the trace block.
// Assumes pclk is the bench clock; every pin changes just after a rising edge.
`timescale 1ns/1ps
module cpu_bus_model (
   // Clock
   input wire logic pclk,
   // Processor pins
   output logic [27:0] addr_lo,
   output logic [3:0] addr_hi,
   output logic [3:0] recon_addr,
   output logic [31:0] data,
   output logic [3:0] func_code,
   output logic rd_wr,
   output logic xfer_size_low,
   output logic xfer_size_high,
   output logic port_ack_low_n,
   output logic port_ack_high_n,
   output logic bus_err_n,
   output logic halt_n,
   output logic show_cycle_n,
   output logic fetch_n,
   output logic ext_dma,
   output logic pipe_flush,
   output logic cycle_done
);
   // ****************************************
   // Pin drive, s uses the status field order
   // ****************************************
   task automatic pins(input logic [31:0] a, input logic [31:0] d, input logic [15:0] s);
      {addr_hi, addr_lo} <= a;
      recon_addr <= a[31:28] ^ 4'h5;
      data <= d;
      func_code <= {s[14], s[3:1]};
      rd_wr <= s[4];
      {xfer_size_high, xfer_size_low} <= s[6:5];
      {port_ack_high_n, port_ack_low_n} <= s[8:7];
      {show_cycle_n, halt_n, bus_err_n} <= s[11:9];
      ext_dma <= ~s[13];
      fetch_n <= s[15];
   endtask

   initial begin
      pipe_flush = 1'h0;
      cycle_done = 1'h0;
      pins(32'h0, 32'h0, 16'hBFF2);
   end

   // Pins held well around the done edge so the synchronisers see one word
   task automatic bus_cycle(input logic [31:0] a, input logic [31:0] d, input logic [15:0] s);
      @(posedge pclk);
      pins(a, d, s);
      repeat (4) @(posedge pclk);
      cycle_done <= 1'h1;
      repeat (6) @(posedge pclk);
      cycle_done <= 1'h0;
      // Released bus shows inverted address and data; status pins keep the same s
      pins(~a, ~d, s);
      repeat (3) @(posedge pclk);
   endtask

   task automatic flush_pulse();
      @(posedge pclk);
      pipe_flush <= 1'h1;
      repeat (4) @(posedge pclk);
      pipe_flush <= 1'h0;
      repeat (4) @(posedge pclk);
   endtask
endmodule

// File: verif/tb_bus_trace_status_qualifier.sv
// Self-checking bench for the trace capture and qualifier block.
// Assumes the processor model and the APB tasks share pclk.
`timescale 1ns/1ps
module tb_bus_trace_status_qualifier;
   import trace_qual_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv, data;
   logic [27:0] addr_lo;
   logic [3:0] addr_hi, recon_addr, func_code;
   logic rd_wr, xfer_size_low, xfer_size_high, port_ack_low_n, port_ack_high_n;
   logic bus_err_n, halt_n, show_cycle_n, fetch_n, ext_dma, pipe_flush, cycle_done;
   logic triggered, trace_full, store_pulse;
   logic [NUM_EQ-1:0] eq_hits;
   logic [79:0] ew;
   int num_errors = 0;
   int n_checks = 0;
   int n_stored = 0;

   // Store pulses are counted off the edge so each one lands once
   always @(negedge pclk) begin
      if (store_pulse === 1'h1) n_stored++;
   end

   bus_trace_status_qualifier dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .addr_lo, .addr_hi, .recon_addr, .data,
      .func_code, .rd_wr, .xfer_size_low, .xfer_size_high, .port_ack_low_n,
      .port_ack_high_n, .bus_err_n, .halt_n, .show_cycle_n, .fetch_n, .ext_dma,
      .pipe_flush, .cycle_done, .triggered, .trace_full, .store_pulse, .eq_hits);
   cpu_bus_model cpu (.pclk, .addr_lo, .addr_hi, .recon_addr, .data, .func_code,
      .rd_wr, .xfer_size_low, .xfer_size_high, .port_ack_low_n, .port_ack_high_n,
      .bus_err_n, .halt_n, .show_cycle_n, .fetch_n, .ext_dma, .pipe_flush, .cycle_done);

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (n == 20) num_errors++;
      rv = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic finish_test();
      if (num_errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // One bus state, then the captured word and equate hits read back
   task automatic cap(input logic [31:0] a, d, input logic [15:0] s, input logic f, rc);
      logic [15:0] st;
      logic [NUM_EQ-1:0] eh;
      logic [79:0] w;
      st = {s[15:13], f, s[11:1], 1'h0};
      for (int i = 0; i < NUM_EQ; i++) begin
         eh[i] = ((st ^ EQ_TAB[i][15:0]) & EQ_TAB[i][31:16]) == 16'h0000;
      end
      ew = {st, d, rc ? (a[31:28] ^ 4'h5) : a[31:28], a[27:0]};
      cpu.bus_cycle(a, d, s);
      apb(0, REG_CUR0, 0);
      w[31:0] = rv;
      apb(0, REG_CUR1, 0);
      w[63:32] = rv;
      apb(0, REG_CUR2, 0);
      w[79:64] = rv[15:0];
      chk("cur_word", ew, w);
      apb(0, REG_EQHIT, 0);
      chk("eq_reg", eh, rv[NUM_EQ-1:0]);
      chk("eq_port", eh, eq_hits);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      apb(0, REG_CTRL, 0);
      chk("ctrl_reset", CTRL_RST, rv);
      apb(0, 12'h044, 0);
      chk("care_reset", QREG_RST, rv);
      apb(1, 12'h054, 32'hFFFF_FFFF);
      chk("unmapped_err", 1, er);
      apb(0, 12'h054, 0);
      chk("unmapped_data", 0, rv);
   endtask

   task automatic t_fields();
      logic [15:0] tab [5] = '{16'h3F1E, 16'h9EAA, 16'hF85C, 16'hBBF2, 16'hBD84};
      logic [79:0] e0;
      logic [79:0] w;
      apb(1, REG_CTRL, 32'h0000_0019);
      for (int i = 0; i < 5; i++) begin
         cap({tab[i], 16'hC3A5}, ~{tab[i], tab[i]}, tab[i], 1'h1, 1'h0);
         if (i == 0) e0 = ew;
      end
      apb(1, REG_CTRL, 32'h0000_000D);
      cap(32'hE000_1000, 32'h0000_0001, 16'hBFF2, 1'h1, 1'h1);
      cpu.flush_pulse();
      cap(32'h0000_0100, 32'h0000_0002, 16'h3F1E, 1'h0, 1'h1);
      cap(32'h0000_0104, 32'h0000_0003, 16'h3F1E, 1'h1, 1'h1);
      // Index is read back first; the word is valid one cycle after the write
      apb(1, REG_RDIDX, 0);
      apb(0, REG_RDIDX, 0);
      apb(0, REG_TW0, 0);
      w[31:0] = rv;
      apb(0, REG_TW1, 0);
      w[63:32] = rv;
      apb(0, REG_TW2, 0);
      w[79:64] = rv[15:0];
      chk("trace_word", e0, w);
   endtask

   task automatic t_refuse();
      logic [10:0] p;
      apb(1, REG_CTRL, 32'h0000_0001);
      apb(0, REG_STAT, 0);
      p = rv[26:16];
      cpu.bus_cycle(32'h0000_2000, 32'h1, 16'hB7F2);
      apb(1, 12'h070, 32'h0010_0000);
      cpu.bus_cycle(32'h0000_2000, 32'h2, 16'hBFF2);
      apb(0, REG_STAT, 0);
      chk("wptr_refused", p, rv[26:16]);
      cpu.bus_cycle(32'h0000_2000, 32'h3, 16'hBFE2);
      apb(0, REG_STAT, 0);
      chk("wptr_stored", p + 11'h1, rv[26:16]);
      apb(1, 12'h070, 0);
   endtask

   task automatic t_trig();
      apb(1, REG_CTRL, 32'h0000_0019);
      // The clear lands on the access edge, so look once it has settled
      @(negedge pclk);
      chk("trig_clear", 0, triggered);
      apb(1, 12'h040, 32'h0000_3000);
      apb(1, 12'h044, 32'hFFFF_FFFF);
      apb(1, 12'h050, 32'h0010_0010);
      cpu.bus_cycle(32'h0000_3000, 32'h5, 16'hBFE2);
      cpu.bus_cycle(32'h0000_3004, 32'h5, 16'hBFF2);
      chk("trig_miss", 0, triggered);
      cpu.bus_cycle(32'h0000_3000, 32'h5, 16'hBFF2);
      chk("trig_hit", 1, triggered);
      apb(0, REG_TRIGPOS, 0);
      chk("trig_pos", 2, rv);
      apb(1, 12'h050, 0);
      apb(1, 12'h044, 0);
   endtask

   task automatic t_depth(input logic c, input logic [10:0] dep);
      int s0;
      apb(1, REG_CTRL, {27'h0, 1'h1, 1'h1, 1'h0, c, 1'h1});
      s0 = n_stored;
      for (int i = 1; i <= dep; i++) begin
         cpu.bus_cycle({21'h0, i[10:0]}, 32'h0, 16'hBFF2);
         if (i == dep - 1) chk("full_early", 0, trace_full);
      end
      chk("full", 1, trace_full);
      apb(0, REG_STAT, 0);
      chk("wptr_full", dep, rv[26:16]);
      chk("stores", dep, n_stored - s0);
      apb(0, REG_SCNT, 0);
      chk("state_count", c ? dep : 11'h000, rv);
   endtask

   // ****************************************
   // Clock, run and watchdog
   // ****************************************
   initial begin
      pclk = 1'h0;
      forever #25 pclk = ~pclk;
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      t_reset();
      t_fields();
      t_refuse();
      t_trig();
      t_depth(1'h1, DEPTH_CNT);
      t_depth(1'h0, DEPTH_FULL);
      finish_test();
   end

   // Full run is near 22000 cycles; this allows more than twice that
   initial begin
      #3000000;
      num_errors++;
      finish_test();
   end
endmodule
